// ### pkg/lvd_pkg.sv
// Package for the low-voltage detect control block: offsets, fields, types.
// Assumes a 32-bit APB slave on pclk at 200 MHz.
`default_nettype none
package lvd_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] LVD_OFF_CTRL = 8'h00;
  localparam logic [7:0] LVD_OFF_LEVEL = 8'h04;
  localparam logic [7:0] LVD_OFF_RAM_DATA_STATUS_REG = 8'h08;
  localparam logic [7:0] LVD_OFF_PROT = 8'h0C;
  localparam logic [7:0] LVD_OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] LVD_OFF_IRQ_MASK = 8'h14;
  // ==========================================================
  // Field positions
  localparam int LVD_BIT_MODE = 1;
  localparam int LVD_BIT_EN = 7;
  localparam int LVD_BIT_FLAG = 0;
  localparam int LVD_BIT_LEVEL = 0;
  localparam int LVD_BIT_RAM_DATA_STATUS_REG = 0;
  localparam int LVD_ADDR_W = 8;
  localparam int LVD_LEVEL_W = 1;
  localparam logic [7:0] LVD_PROT_KEY = 8'hA5;
  localparam logic [1:0] LVD_LEVEL_RST = 2'h0;
  // ==========================================================
  // Timing
  localparam int LVD_CLK_MHZ = 200;
  localparam int LVD_SETTLE_US = 200;
  localparam int LVD_SETTLE_CYC = LVD_SETTLE_US * LVD_CLK_MHZ;
  localparam int LVD_CNT_W = 16;
  // ==========================================================
  // Types
  typedef struct packed {
    logic wdt;
    logic ram_access;
    logic clk_mon;
    logic ext;
  } lvd_rst_src_t;
  typedef struct packed {
    logic ram_set;
    logic settle_done;
    logic lock_set;
    logic detect;
  } lvd_irq_t;
  typedef enum logic [1:0] {LVD_OFF, LVD_SETTLE, LVD_ON, LVD_LOCKED} lvd_state_t;
endpackage
`default_nettype wire

// ### rtl/lvd_sync.sv
// Two flip-flop synchroniser for the analog comparator output.
// Assumes the input is asynchronous to pclk.
`default_nettype none
module lvd_sync
  import lvd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // lvd_sync

// ### rtl/lvd_settle.sv
// Settling timer: counts the detector start-up time after enable.
// Assumes run is a level on pclk, held high while the detector is enabled; low clears the count.
`default_nettype none
module lvd_settle
  import lvd_pkg::*;
#(
  parameter int SETTLE_CYC = LVD_SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic done
);
  logic [LVD_CNT_W-1:0] count;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      done <= 1'b0;
    end else if (!run) begin
      count <= '0;
      done <= 1'b0;
    end else if (count == LVD_CNT_W'(SETTLE_CYC - 1)) begin
      done <= 1'b1;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule // lvd_settle

// ### rtl/lvd_ctrl.sv
// Low-voltage detect control: APB registers, lock, routing, RAM status flag.
// Assumes an APB master on pclk and level reset-source inputs on pclk.
//
// The APB register port and the register addresses were chosen for this implementation.
`default_nettype none
// How it works
// - Interrupt output follows the flag when enabled and reset mode off.
// - Enable plus reset mode locks detector on until a non-detector reset.
// - Level select writes are ignored while the lock holds.
// - RAM status sets on low supply and on software set.
// - RAM status sets on watchdog, RAM-access and clock-monitor resets.
// - RAM status clears only by writing zero after the protect key.
module lvd_ctrl
  import lvd_pkg::*;
#(
  parameter int SETTLE_CYC = LVD_SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [LVD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_low,
  input wire lvd_rst_src_t rst_src,
  output logic detector_on,
  output logic [LVD_LEVEL_W-1:0] level_sel,
  output logic low_supply_flag,
  output logic low_supply_irq,
  output logic lvd_reset_req,
  output logic settled,
  output logic irq
);
  // ==========================================================
  // Bus decode
  logic wr_en;
  logic rd_en;
  logic detector_enable_bit;
  logic detect_reset_mode_bit;
  logic locked;
  logic prot_armed;
  logic ram_data_status_reg;
  logic comp_sync;
  lvd_state_t state;
  lvd_irq_t irq_stat;
  lvd_irq_t irq_mask;
  lvd_irq_t irq_event;
  logic other_reset;
  logic settle_q;

  function automatic logic hit(input logic [LVD_ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign other_reset = |rst_src;

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      pslverr = !(hit(paddr, LVD_OFF_CTRL) || hit(paddr, LVD_OFF_LEVEL) ||
                  hit(paddr, LVD_OFF_RAM_DATA_STATUS_REG) || hit(paddr, LVD_OFF_PROT) ||
                  hit(paddr, LVD_OFF_IRQ_STAT) || hit(paddr, LVD_OFF_IRQ_MASK));
    end
  end

  // ==========================================================
  // Detector control and lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detector_enable_bit <= 1'b0;
      detect_reset_mode_bit <= 1'b0;
      locked <= 1'b0;
    end else if (other_reset) begin
      detector_enable_bit <= 1'b0;
      detect_reset_mode_bit <= 1'b0;
      locked <= 1'b0;
    end else if (locked) begin
      detector_enable_bit <= 1'b1;
      detect_reset_mode_bit <= 1'b1;
    end else begin
      if (wr_en && hit(paddr, LVD_OFF_CTRL) &&
          !(detector_enable_bit && detect_reset_mode_bit)) begin
        detector_enable_bit <= pwdata[LVD_BIT_EN];
        detect_reset_mode_bit <= pwdata[LVD_BIT_MODE];
      end
      locked <= detector_enable_bit && detect_reset_mode_bit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_sel <= LVD_LEVEL_RST[LVD_LEVEL_W-1:0];
    end else if (other_reset) begin
      level_sel <= LVD_LEVEL_RST[LVD_LEVEL_W-1:0];
    end else if (wr_en && hit(paddr, LVD_OFF_LEVEL) && !locked &&
                 !(detector_enable_bit && detect_reset_mode_bit)) begin
      level_sel <= pwdata[LVD_BIT_LEVEL +: LVD_LEVEL_W];
    end
  end

  assign detector_on = detector_enable_bit;

  // ==========================================================
  // Detection path
  lvd_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(comparator_low),
    .sync_out(comp_sync)
  );

  lvd_settle #(.SETTLE_CYC(SETTLE_CYC)) u_settle (
    .pclk(pclk),
    .presetn(presetn),
    .run(detector_enable_bit),
    .done(settle_q)
  );

  assign settled = settle_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_supply_flag <= 1'b0;
    end else begin
      low_supply_flag <= detector_enable_bit && comp_sync;
    end
  end

  assign low_supply_irq = low_supply_flag && detector_enable_bit &&
                          !detect_reset_mode_bit;
  assign lvd_reset_req = low_supply_flag && detector_enable_bit &&
                         detect_reset_mode_bit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= LVD_OFF;
    end else begin
      case (state)
        LVD_OFF: if (detector_enable_bit) state <= LVD_SETTLE;
        LVD_SETTLE: begin
          if (!detector_enable_bit) state <= LVD_OFF;
          else if (locked) state <= LVD_LOCKED;
          else if (settle_q) state <= LVD_ON;
        end
        LVD_ON: begin
          if (!detector_enable_bit) state <= LVD_OFF;
          else if (locked) state <= LVD_LOCKED;
        end
        LVD_LOCKED: if (!locked) state <= LVD_OFF;
        default: state <= LVD_OFF;
      endcase
    end
  end

  // ==========================================================
  // RAM data status flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_armed <= 1'b0;
    end else if (wr_en) begin
      prot_armed <= hit(paddr, LVD_OFF_PROT) && (pwdata[7:0] == LVD_PROT_KEY);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_data_status_reg <= 1'b0;
    end else if (low_supply_flag || rst_src.wdt || rst_src.ram_access ||
                 rst_src.clk_mon) begin
      ram_data_status_reg <= 1'b1;
    end else if (wr_en && hit(paddr, LVD_OFF_RAM_DATA_STATUS_REG)) begin
      if (pwdata[LVD_BIT_RAM_DATA_STATUS_REG]) begin
        ram_data_status_reg <= 1'b1;
      end else if (prot_armed) begin
        ram_data_status_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Interrupt status and mask
  assign irq_event.detect = low_supply_irq;
  assign irq_event.lock_set = detector_enable_bit && detect_reset_mode_bit && !locked;
  assign irq_event.settle_done = (state == LVD_SETTLE) && settle_q;
  assign irq_event.ram_set = !ram_data_status_reg && (low_supply_flag || rst_src.wdt ||
                             rst_src.ram_access || rst_src.clk_mon);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else if (rd_en && hit(paddr, LVD_OFF_IRQ_STAT)) begin
      irq_stat <= irq_event;
    end else begin
      irq_stat <= irq_stat | irq_event;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= '0;
    end else if (wr_en && hit(paddr, LVD_OFF_IRQ_MASK)) begin
      irq_mask <= pwdata[$bits(lvd_irq_t)-1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ==========================================================
  // Read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= '0;
      if (hit(paddr, LVD_OFF_CTRL)) begin
        prdata[LVD_BIT_EN] <= detector_enable_bit;
        prdata[LVD_BIT_MODE] <= detect_reset_mode_bit;
        prdata[LVD_BIT_FLAG] <= low_supply_flag;
      end else if (hit(paddr, LVD_OFF_LEVEL)) begin
        prdata[LVD_BIT_LEVEL +: LVD_LEVEL_W] <= level_sel;
      end else if (hit(paddr, LVD_OFF_RAM_DATA_STATUS_REG)) begin
        prdata[LVD_BIT_RAM_DATA_STATUS_REG] <= ram_data_status_reg;
      end else if (hit(paddr, LVD_OFF_IRQ_STAT)) begin
        prdata[$bits(lvd_irq_t)-1:0] <= irq_stat | irq_event;
      end else if (hit(paddr, LVD_OFF_IRQ_MASK)) begin
        prdata[$bits(lvd_irq_t)-1:0] <= irq_mask;
      end
    end
  end

  // ==========================================================
  // Checks
  sequence s_lock_armed;
    detector_enable_bit && detect_reset_mode_bit && !other_reset;
  endsequence

  sequence s_key_write;
    wr_en && hit(paddr, LVD_OFF_PROT) && (pwdata[7:0] == LVD_PROT_KEY);
  endsequence

  sequence s_clear_write;
    wr_en && hit(paddr, LVD_OFF_RAM_DATA_STATUS_REG) && !pwdata[LVD_BIT_RAM_DATA_STATUS_REG];
  endsequence

  // ==========================================================
  // Properties
  a_irq_route: assert property (@(posedge pclk) disable iff (!presetn)
    detector_enable_bit && !detect_reset_mode_bit |-> low_supply_irq == low_supply_flag)
    else $error("irq route wrong");
  a_lock_arms: assert property (@(posedge pclk) disable iff (!presetn)
    s_lock_armed |=> locked)
    else $error("lock not armed");
  a_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
    s_lock_armed ##1 !other_reset |=> detector_enable_bit)
    else $error("lock lost");
  a_ctrl_refused: assert property (@(posedge pclk) disable iff (!presetn)
    locked && !other_reset |=> detector_enable_bit && detect_reset_mode_bit)
    else $error("control changed under lock");
  a_lock_release: assert property (@(posedge pclk) disable iff (!presetn)
    other_reset |=> !locked && !detector_enable_bit)
    else $error("lock not released");
  a_level_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    locked && !other_reset |=> $stable(level_sel))
    else $error("level changed under lock");
  a_ram_set_low: assert property (@(posedge pclk) disable iff (!presetn)
    low_supply_flag |=> ram_data_status_reg)
    else $error("ram flag not set");
  a_ram_set_rst: assert property (@(posedge pclk) disable iff (!presetn)
    (rst_src.wdt || rst_src.ram_access || rst_src.clk_mon) |=> ram_data_status_reg)
    else $error("ram flag not set by reset");
  a_ram_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(ram_data_status_reg) |-> $past(prot_armed) && $past(wr_en))
    else $error("ram flag cleared without key");
  a_ram_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ram_data_status_reg && !prot_armed |=> ram_data_status_reg)
    else $error("ram flag dropped while unarmed");
  a_key_arms: assert property (@(posedge pclk) disable iff (!presetn)
    s_key_write |=> prot_armed)
    else $error("key write did not arm");
  a_ram_key_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s_key_write ##1 (!wr_en) [*2] ##1 s_clear_write ##0
    !(low_supply_flag || rst_src.wdt || rst_src.ram_access || rst_src.clk_mon)
    |=> !ram_data_status_reg)
    else $error("ram flag not cleared by key");
  a_reset_route: assert property (@(posedge pclk) disable iff (!presetn)
    lvd_reset_req |-> !low_supply_irq && detect_reset_mode_bit)
    else $error("reset route wrong");
  a_flag_follow: assert property (@(posedge pclk) disable iff (!presetn)
    detector_enable_bit && comp_sync |=> low_supply_flag)
    else $error("flag not following");
  a_flag_off: assert property (@(posedge pclk) disable iff (!presetn)
    !detector_enable_bit |=> !low_supply_flag)
    else $error("flag high while detector off");
  a_stat_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    irq_event.detect |=> irq_stat.detect)
    else $error("detect event lost");
endmodule // lvd_ctrl
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the low-voltage detect control block.
// Assumes lvd_ctrl on APB with zero-wait answers and SETTLE_CYC set to 8.
`default_nettype none
module tb;
  import lvd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic e;
  } lvd_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [LVD_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic comparator_low = 1'b0;
  lvd_rst_src_t rst_src = '0;
  logic detector_on;
  logic [LVD_LEVEL_W-1:0] level_sel;
  logic low_supply_flag;
  logic low_supply_irq;
  logic lvd_reset_req;
  logic settled;
  logic irq;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic er;
  lvd_row_t rows [5];
  lvd_ctrl #(.SETTLE_CYC(8)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comparator_low(comparator_low),
    .rst_src(rst_src), .detector_on(detector_on), .level_sel(level_sel),
    .low_supply_flag(low_supply_flag), .low_supply_irq(low_supply_irq),
    .lvd_reset_req(lvd_reset_req), .settled(settled), .irq(irq)
  );
  always #2.5 pclk = ~pclk;
  // ==========================================================
  // Tasks
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    chk(rd, exp);
  endtask
  task automatic ram_data_status_reg_clear();
    apb(1'b1, LVD_OFF_PROT, {24'h0, LVD_PROT_KEY});
    apb(1'b1, LVD_OFF_RAM_DATA_STATUS_REG, 32'h0);
  endtask
  task automatic pulse_src(input lvd_rst_src_t s);
    rst_src <= s;
    @(posedge pclk);
    rst_src <= '0;
    @(posedge pclk);
  endtask
  // ==========================================================
  // Sequence
  initial begin
    rows[0] = '{LVD_OFF_IRQ_MASK, 32'hF, 32'hF, 1'b0};
    rows[1] = '{LVD_OFF_LEVEL, 32'h1, 32'h1, 1'b0};
    rows[2] = '{LVD_OFF_CTRL, 32'h0, 32'h0, 1'b0};
    rows[3] = '{LVD_OFF_RAM_DATA_STATUS_REG, 32'h1, 32'h1, 1'b0};
    rows[4] = '{8'h20, 32'h5, 32'h0, 1'b1};
    repeat (6) @(posedge pclk);
    chk({detector_on, irq, lvd_reset_req, settled}, 32'h0);
    chk(pready, 1'b1);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      chk(er, rows[i].e);
      apb(1'b0, rows[i].a, '0);
      chk(rd, rows[i].q);
      chk(er, rows[i].e);
    end
    ram_data_status_reg_clear();
    rd_chk(LVD_OFF_RAM_DATA_STATUS_REG, 32'h0);
    // Interrupt mode, low supply
    apb(1'b1, LVD_OFF_CTRL, 32'h80);
    comparator_low <= 1'b1;
    repeat (12) @(posedge pclk);
    chk({low_supply_flag, low_supply_irq}, 32'h3);
    chk(settled, 1'b1);
    chk({lvd_reset_req, settled, irq}, 32'h3);
    rd_chk(LVD_OFF_CTRL, 32'h81);
    rd_chk(LVD_OFF_RAM_DATA_STATUS_REG, 32'h1);
    comparator_low <= 1'b0;
    repeat (5) @(posedge pclk);
    chk({low_supply_flag, low_supply_irq}, 32'h0);
    chk(irq, 1'b1);
    rd_chk(LVD_OFF_IRQ_STAT, 32'hD);
    chk(irq, 1'b0);
    rd_chk(LVD_OFF_IRQ_STAT, 32'h0);
    apb(1'b1, LVD_OFF_IRQ_MASK, 32'h0);
    // Clear needs the key write just before
    apb(1'b1, LVD_OFF_RAM_DATA_STATUS_REG, 32'h0);
    rd_chk(LVD_OFF_RAM_DATA_STATUS_REG, 32'h1);
    ram_data_status_reg_clear();
    rd_chk(LVD_OFF_RAM_DATA_STATUS_REG, 32'h0);
    // Reset mode locks the detector
    apb(1'b1, LVD_OFF_LEVEL, 32'h1);
    apb(1'b1, LVD_OFF_CTRL, 32'h82);
    repeat (2) @(posedge pclk);
    comparator_low <= 1'b1;
    repeat (5) @(posedge pclk);
    chk({lvd_reset_req, low_supply_irq}, 32'h2);
    rd_chk(LVD_OFF_IRQ_STAT, 32'hA);
    apb(1'b1, LVD_OFF_CTRL, 32'h0);
    chk(detector_on, 1'b1);
    apb(1'b1, LVD_OFF_LEVEL, 32'h0);
    chk(level_sel, 1'b1);
    comparator_low <= 1'b0;
    pulse_src(4'b0001);
    chk({detector_on, level_sel}, 32'h0);
    ram_data_status_reg_clear();
    pulse_src(4'b0001);
    rd_chk(LVD_OFF_RAM_DATA_STATUS_REG, 32'h0);
    for (int i = 0; i < 3; i++) begin
      pulse_src(lvd_rst_src_t'(4'b1000 >> i));
      rd_chk(LVD_OFF_RAM_DATA_STATUS_REG, 32'h1);
      ram_data_status_reg_clear();
    end
    end_of_test();
  end
endmodule // tb
`default_nettype wire
